// ===== design/fault_event_interrupt_ctrl.sv
// Functional notes
// - unmasked condition sends a message from programmed data and target
// - mask bit 31 resets to one and blocks any message while set
// - pending bit 30 is set whenever an interrupt condition is detected
// - primary logging: fault recorded, primary flag set, is a condition
// - advanced logging: first log record written and flag set is a condition
// - invalidation queue error flag setting is a condition
// - invalid remote cache completion flag setting is a condition
// - remote cache completion time-out flag setting is a condition
// - no new condition while any fault status flag is already set
// - pending stays set while the message is unsent and any status flag is set
// - pending clears on message sent or software clearing all status flags
// - primary pending flag is the OR of all record valid bits
// - message payload is message data bits 15:0
// - message address is the dword-aligned target bits 31:2
`timescale 1ns/1ps

module fault_event_interrupt_ctrl
   import fault_event_pkg::*;
#(
   parameter int RECORDS = RECORDS_DEFAULT
) (
   // clock and reset
   input  wire logic                 clk,
   input  wire logic                 rst,
   // register port
   input  wire logic [ADDR_W-1:0]    reg_addr,
   input  wire logic [DATA_W-1:0]    reg_wdata,
   input  wire logic                 reg_wr,
   input  wire logic                 reg_rd,
   output logic      [DATA_W-1:0]    reg_rdata,
   // fault sources
   input  wire logic [RECORDS-1:0]   fault_record_valid,
   input  wire logic                 adv_log_active,
   input  wire logic                 adv_first_record_set,
   input  wire logic                 adv_overflow_set,
   input  wire logic                 fault_overflow_set,
   input  wire logic                 queue_error_set,
   input  wire logic                 bad_completion_set,
   input  wire logic                 completion_timeout_set,
   // interrupt message
   output logic                      msg_valid,
   input  wire logic                 msg_ready,
   output logic      [DATA_W-1:0]    msg_target,
   output logic      [PAYLOAD_W-1:0] msg_payload,
   // local interrupt
   output logic                      irq
);

   // ------------------------------------------------------------------
   // declarations
   // ------------------------------------------------------------------
   logic                  message_mask;
   logic                  message_pending;
   logic [PAYLOAD_W-1:0]  message_payload;
   logic [TARGET_W-1:0]   message_target;
   logic [STATUS_W-1:0]   sticky;
   logic [STATUS_W-1:0]   irq_mask;
   logic                  primary_pending_fault;
   logic                  primary_q;
   logic                  primary_rise;
   logic                  status_any;
   logic                  new_cond;
   logic                  sent;
   logic [STATUS_W-1:0]   set_vec;
   logic [STATUS_W-1:0]   clr_vec;
   logic [STATUS_W-1:0]   status_view;
   reg_sel_e              sel;
   logic                  wr_status;

   assign sel       = decode_reg(reg_addr);
   assign wr_status = reg_wr && (sel == SEL_STATUS);

   // ------------------------------------------------------------------
   // fault status flags
   // ------------------------------------------------------------------
   assign primary_pending_fault = |fault_record_valid;

   always_comb begin
      set_vec = '0;
      set_vec[POS_FAULT_OVERFLOW] = fault_overflow_set;
      set_vec[POS_ADV_OVERFLOW]   = adv_overflow_set && adv_log_active;
      set_vec[POS_ADV_FIRST]      = adv_first_record_set
                                    && adv_log_active;
      set_vec[POS_QUEUE_ERROR]    = queue_error_set;
      set_vec[POS_BAD_COMPLETION] = bad_completion_set;
      set_vec[POS_COMPL_TIMEOUT]  = completion_timeout_set;
   end

   // live flag is not sticky, so never clearable by a write
   always_comb begin
      clr_vec = '0;
      if (wr_status) begin
         clr_vec = reg_wdata[STATUS_W-1:0];
      end
      clr_vec[POS_PRIMARY_PENDING] = 1'b0;
   end

   // a set in the clearing cycle wins
   always_ff @(posedge clk) begin
      if (rst) begin
         sticky <= STATUS_RESET;
      end else begin
         sticky <= (sticky & ~clr_vec) | set_vec;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         primary_q <= 1'b0;
      end else begin
         primary_q <= primary_pending_fault;
      end
   end

   always_comb begin
      status_view = sticky;
      status_view[POS_PRIMARY_PENDING] = primary_pending_fault;
   end

   // ------------------------------------------------------------------
   // condition detection
   // ------------------------------------------------------------------
   assign status_any   = (|sticky) || primary_q;
   assign primary_rise = primary_pending_fault && !primary_q
                         && !adv_log_active;
   assign new_cond     = !status_any
                         && (primary_rise || |(set_vec & COND_BITS));

   // ------------------------------------------------------------------
   // pending bit and message
   // ------------------------------------------------------------------
   assign msg_valid = message_pending && !message_mask;
   assign sent      = msg_valid && msg_ready;

   always_ff @(posedge clk) begin
      if (rst) begin
         message_pending <= 1'b0;
      end else if (new_cond) begin
         message_pending <= 1'b1;
      end else if (sent || !status_any) begin
         message_pending <= 1'b0;
      end
   end

   assign msg_payload = message_payload;
   assign msg_target  = {message_target, 2'b00};

   // ------------------------------------------------------------------
   // software registers
   // ------------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (rst) begin
         message_mask <= MASK_RESET;
      end else if (reg_wr && sel == SEL_CONTROL) begin
         message_mask <= reg_wdata[POS_MESSAGE_MASK];
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         message_payload <= MSG_DATA_RESET;
      end else if (reg_wr && sel == SEL_DATA) begin
         message_payload <= reg_wdata[PAYLOAD_W-1:0];
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         message_target <= MSG_TARGET_RESET;
      end else if (reg_wr && sel == SEL_TARGET) begin
         message_target <= reg_wdata[DATA_W-1:TARGET_LSB];
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         irq_mask <= IRQ_MASK_RESET;
      end else if (reg_wr && sel == SEL_IRQ_MASK) begin
         irq_mask <= reg_wdata[STATUS_W-1:0];
      end
   end

   assign irq = |(status_view & ~irq_mask);

   // ------------------------------------------------------------------
   // read data, one cycle after the strobe
   // ------------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (rst) begin
         reg_rdata <= '0;
      end else if (reg_rd) begin
         reg_rdata <= '0;
         unique case (sel)
            SEL_STATUS: begin
               reg_rdata[STATUS_W-1:0] <= status_view;
            end
            SEL_CONTROL: begin
               reg_rdata[POS_MESSAGE_MASK]    <= message_mask;
               reg_rdata[POS_MESSAGE_PENDING] <= message_pending;
            end
            SEL_DATA: begin
               reg_rdata[PAYLOAD_W-1:0] <= message_payload;
            end
            SEL_TARGET: begin
               reg_rdata[DATA_W-1:TARGET_LSB] <= message_target;
            end
            SEL_IRQ_MASK: begin
               reg_rdata[STATUS_W-1:0] <= irq_mask;
            end
            SEL_NONE: begin
               reg_rdata <= '0;
            end
         endcase
      end else begin
         reg_rdata <= '0;
      end
   end

   // ------------------------------------------------------------------
   // checks
   // ------------------------------------------------------------------
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   sequence s_send;
      msg_valid && msg_ready;
   endsequence

   sequence s_quiet;
      !status_any && !new_cond;
   endsequence

   sequence s_offer_waits;
      msg_valid && !msg_ready && status_any;
   endsequence

   chk_mask_blocks_msg: assert property (
      message_mask |-> !msg_valid)
      else $error("message offered while masked");

   chk_unmasked_offer: assert property (
      (message_pending && !message_mask) |-> msg_valid)
      else $error("unmasked pending message not offered");

   chk_cond_sets_pending: assert property (
      new_cond |=> message_pending && status_any)
      else $error("condition did not set pending");

   chk_primary_or: assert property (
      status_view[POS_PRIMARY_PENDING] == |fault_record_valid)
      else $error("primary pending flag not OR of records");

   chk_primary_cond: assert property (
      (!status_any && !adv_log_active && !primary_q
       && |fault_record_valid) |=> message_pending)
      else $error("recorded fault did not raise pending");

   chk_adv_first_cond: assert property (
      (!status_any && adv_log_active && adv_first_record_set)
      |=> message_pending && sticky[POS_ADV_FIRST])
      else $error("first log record did not raise pending");

   chk_queue_err_cond: assert property (
      (!status_any && queue_error_set)
      |=> message_pending && sticky[POS_QUEUE_ERROR])
      else $error("queue error did not raise pending");

   chk_bad_compl_cond: assert property (
      (!status_any && bad_completion_set)
      |=> message_pending && sticky[POS_BAD_COMPLETION])
      else $error("bad completion did not raise pending");

   chk_timeout_cond: assert property (
      (!status_any && completion_timeout_set)
      |=> message_pending && sticky[POS_COMPL_TIMEOUT])
      else $error("time-out did not raise pending");

   chk_busy_no_cond: assert property (
      (status_any && !message_pending) |=> !message_pending)
      else $error("new condition while a flag was set");

   chk_pending_holds: assert property (
      (message_pending && !(msg_valid && msg_ready) && status_any)
      |=> message_pending)
      else $error("pending dropped while unsent");

   chk_send_clears: assert property (
      (s_send ##0 !new_cond) |=> !message_pending && !msg_valid)
      else $error("pending not cleared after send");

   chk_sw_clears: assert property (
      s_quiet |=> !message_pending)
      else $error("pending kept after flags cleared");

   chk_w1c_clears: assert property (
      (wr_status && reg_wdata[POS_QUEUE_ERROR] && !queue_error_set)
      |=> !sticky[POS_QUEUE_ERROR])
      else $error("write one did not clear flag");

   chk_w0_keeps: assert property (
      (wr_status && !reg_wdata[POS_QUEUE_ERROR]
       && sticky[POS_QUEUE_ERROR]) |=> sticky[POS_QUEUE_ERROR])
      else $error("write zero changed a flag");

   chk_payload_addr: assert property (
      (reg_wr && sel == SEL_DATA) |=>
      msg_payload == $past(reg_wdata[PAYLOAD_W-1:0])
      && msg_target[TARGET_LSB-1:0] == 2'b00)
      else $error("payload or target wrong");

   chk_masked_keeps: assert property (
      (message_pending && message_mask && status_any) |=> message_pending)
      else $error("masked pending dropped");

   chk_offer_holds: assert property (
      (s_offer_waits ##0 !(reg_wr && sel == SEL_CONTROL)) |=> msg_valid)
      else $error("offer withdrawn while unsent");

   chk_idle_no_offer: assert property (
      !message_pending |-> !msg_valid)
      else $error("message offered with nothing pending");

   chk_pending_needs_cond: assert property (
      (!message_pending && !new_cond) |=> !message_pending)
      else $error("pending set without a condition");

   chk_target_write: assert property (
      (reg_wr && sel == SEL_TARGET) |=>
      msg_target[DATA_W-1:TARGET_LSB]
      == $past(reg_wdata[DATA_W-1:TARGET_LSB]))
      else $error("message target not taken from register");

   chk_ctl_reserved: assert property (
      (reg_rd && sel == SEL_CONTROL) |=>
      reg_rdata[POS_MESSAGE_PENDING-1:0] == '0)
      else $error("reserved control bits not zero");

   chk_ctl_read: assert property (
      (reg_rd && sel == SEL_CONTROL) |=>
      reg_rdata[POS_MESSAGE_MASK] == $past(message_mask)
      && reg_rdata[POS_MESSAGE_PENDING] == $past(message_pending))
      else $error("control read does not show mask and pending");

endmodule : fault_event_interrupt_ctrl

// ===== design/fault_event_pkg.sv
package fault_event_pkg;

   // ------------------------------------------------------------------
   // register map
   // ------------------------------------------------------------------
   localparam int          ADDR_W            = 12;
   localparam int          DATA_W            = 32;
   localparam logic [11:0] OFS_FAULT_STATUS  = 12'h034;
   localparam logic [11:0] OFS_EVENT_CONTROL = 12'h038;
   localparam logic [11:0] OFS_MSG_DATA      = 12'h03c;
   localparam logic [11:0] OFS_MSG_TARGET    = 12'h040;
   localparam logic [11:0] OFS_IRQ_MASK      = 12'h048;

   // ------------------------------------------------------------------
   // field positions
   // ------------------------------------------------------------------
   localparam int POS_MESSAGE_MASK    = 31;
   localparam int POS_MESSAGE_PENDING = 30;
   localparam int POS_FAULT_OVERFLOW  = 0;
   localparam int POS_PRIMARY_PENDING = 1;
   localparam int POS_ADV_OVERFLOW    = 2;
   localparam int POS_ADV_FIRST       = 3;
   localparam int POS_QUEUE_ERROR     = 4;
   localparam int POS_BAD_COMPLETION  = 5;
   localparam int POS_COMPL_TIMEOUT   = 6;
   localparam int STATUS_W            = 7;
   localparam int PAYLOAD_W           = 16;
   localparam int TARGET_LSB          = 2;
   localparam int TARGET_W            = DATA_W - TARGET_LSB;
   localparam int RECORDS_DEFAULT     = 8;

   // status bits whose setting is an interrupt condition
   localparam logic [STATUS_W-1:0] COND_BITS = 7'h78;

   // ------------------------------------------------------------------
   // reset values
   // ------------------------------------------------------------------
   localparam logic                  MASK_RESET       = 1'b1;
   localparam logic [PAYLOAD_W-1:0]  MSG_DATA_RESET   = 16'h0000;
   localparam logic [TARGET_W-1:0]   MSG_TARGET_RESET = 30'h00000000;
   localparam logic [STATUS_W-1:0]   STATUS_RESET     = 7'h00;
   localparam logic [STATUS_W-1:0]   IRQ_MASK_RESET   = 7'h7f;

   typedef enum logic [2:0] {
      SEL_NONE,
      SEL_STATUS,
      SEL_CONTROL,
      SEL_DATA,
      SEL_TARGET,
      SEL_IRQ_MASK
   } reg_sel_e;

   function automatic reg_sel_e decode_reg(input logic [ADDR_W-1:0] a);
      reg_sel_e s;
      s = SEL_NONE;
      if (a == OFS_FAULT_STATUS) s = SEL_STATUS;
      if (a == OFS_EVENT_CONTROL) s = SEL_CONTROL;
      if (a == OFS_MSG_DATA) s = SEL_DATA;
      if (a == OFS_MSG_TARGET) s = SEL_TARGET;
      if (a == OFS_IRQ_MASK) s = SEL_IRQ_MASK;
      return s;
   endfunction : decode_reg

endpackage : fault_event_pkg

// ===== sim/fault_event_interrupt_ctrl_tb_top.sv
`timescale 1ns/1ps

module fault_event_interrupt_ctrl_tb_top;
   import fault_event_pkg::*;

   logic                 clk = 1'b0;
   logic                 rst = 1'b1;
   logic [ADDR_W-1:0]    reg_addr = 12'h000;
   logic [DATA_W-1:0]    reg_wdata = 32'h0;
   logic                 reg_wr = 1'b0;
   logic                 reg_rd = 1'b0;
   logic [DATA_W-1:0]    reg_rdata;
   logic [7:0]           frec = 8'h00;
   logic                 adv_on = 1'b0;
   logic [5:0]           ev = 6'h00;
   logic                 msg_valid;
   logic                 msg_ready;
   logic                 irq;
   logic [DATA_W-1:0]    msg_target;
   logic [DATA_W-1:0]    last_target;
   logic [PAYLOAD_W-1:0] msg_payload;
   logic [PAYLOAD_W-1:0] last_payload;
   logic [3:0]           delay = 4'h0;
   logic [7:0]           count;
   logic [7:0]           n;
   logic [31:0]          d;
   int                   n_errors = 0;
   int                   checked = 0;
   int                   cycles = 0;

   always #25 clk = ~clk;

   fault_event_interrupt_ctrl #(.RECORDS(8)) uut (
      .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .fault_record_valid(frec), .adv_log_active(adv_on),
      .adv_first_record_set(ev[3]), .adv_overflow_set(ev[5]),
      .fault_overflow_set(ev[4]), .queue_error_set(ev[0]),
      .bad_completion_set(ev[1]), .completion_timeout_set(ev[2]),
      .msg_valid(msg_valid), .msg_ready(msg_ready),
      .msg_target(msg_target), .msg_payload(msg_payload), .irq(irq));

   msg_sink sink (
      .clk(clk), .rst(rst), .msg_valid(msg_valid), .msg_ready(msg_ready),
      .msg_target(msg_target), .msg_payload(msg_payload), .delay(delay),
      .count(count), .last_target(last_target),
      .last_payload(last_payload));

   // ----------------------------------------------------------------
   // shared tasks
   // ----------------------------------------------------------------
   task automatic end_of_test();
      if (n_errors == 0 && checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : end_of_test

   task automatic chk(input string what, input logic [31:0] exp, got);
      checked++;
      if (got !== exp) begin
         n_errors++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   task automatic wr(input logic [11:0] a, input logic [31:0] v);
      @(posedge clk);
      reg_addr  <= a;
      reg_wdata <= v;
      reg_wr    <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
      #1;
   endtask : wr

   task automatic rd(input logic [11:0] a, output logic [31:0] v);
      @(posedge clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      v = reg_rdata;
   endtask : rd

   task automatic pulse(input int i);
      @(posedge clk);
      ev[i] <= 1'b1;
      @(posedge clk);
      ev[i] <= 1'b0;
   endtask : pulse

   task automatic wait_msg(input logic [7:0] m);
      repeat (30) if (count !== m) begin
         @(posedge clk);
         #1;
      end
      repeat (2) @(posedge clk);
      #1;
   endtask : wait_msg

   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic t_reset();
      rd(OFS_EVENT_CONTROL, d);
      chk("ctl reset", 32'h80000000, d);
      rd(OFS_MSG_DATA, d);
      chk("data reset", 32'h0, d);
      rd(12'h0f0, d);
      chk("unmapped", 32'h0, d);
      rd(OFS_IRQ_MASK, d);
      chk("irq mask reset", 32'h7f, d);
   endtask : t_reset

   task automatic t_masked();
      pulse(0);
      repeat (5) @(posedge clk);
      rd(OFS_EVENT_CONTROL, d);
      chk("masked pending", 32'hc0000000, d);
      chk("masked count", 32'h0, {24'h0, count});
      wr(OFS_FAULT_STATUS, 32'h0);
      rd(OFS_FAULT_STATUS, d);
      chk("w0 keeps flag", 32'h10, d);
      wr(OFS_FAULT_STATUS, 32'h10);
      rd(OFS_EVENT_CONTROL, d);
      chk("sw service", 32'h80000000, d);
   endtask : t_masked

   task automatic t_events();
      wr(OFS_MSG_DATA, 32'habcd5a5a);
      wr(OFS_MSG_TARGET, 32'hfee01237);
      rd(OFS_MSG_TARGET, d);
      chk("target reg", 32'hfee01234, d);
      wr(OFS_EVENT_CONTROL, 32'h0);
      adv_on <= 1'b1;
      for (int i = 0; i < 4; i++) begin
         delay <= i[3:0];
         n = count;
         pulse(i);
         wait_msg(n + 8'h01);
         chk("msg count", {24'h0, n + 8'h01}, {24'h0, count});
         chk("payload", 32'h5a5a, {16'h0, last_payload});
         chk("target", 32'hfee01234, last_target);
         rd(OFS_EVENT_CONTROL, d);
         chk("sent clears", 32'h0, d);
         wr(OFS_FAULT_STATUS, 32'h7f);
         rd(OFS_FAULT_STATUS, d);
         chk("w1c all", 32'h0, d);
      end
   endtask : t_events

   task automatic t_already();
      n = count;
      pulse(4);
      pulse(5);
      pulse(0);
      repeat (5) @(posedge clk);
      #1;
      chk("no new msg", {24'h0, n}, {24'h0, count});
      rd(OFS_FAULT_STATUS, d);
      chk("flags", 32'h15, d);
      wr(OFS_FAULT_STATUS, 32'h15);
   endtask : t_already

   task automatic t_primary();
      adv_on <= 1'b0;
      n = count;
      @(posedge clk);
      frec <= 8'h04;
      wait_msg(n + 8'h01);
      chk("primary msg", {24'h0, n + 8'h01}, {24'h0, count});
      frec <= 8'h0c;
      repeat (5) @(posedge clk);
      #1;
      chk("second rec", {24'h0, n + 8'h01}, {24'h0, count});
      rd(OFS_FAULT_STATUS, d);
      chk("primary flag", 32'h2, d);
      frec <= 8'h00;
      rd(OFS_FAULT_STATUS, d);
      chk("primary clear", 32'h0, d);
   endtask : t_primary

   task automatic t_irq();
      n = count;
      pulse(0);
      wait_msg(n + 8'h01);
      chk("irq masked", 32'h0, {31'h0, irq});
      wr(OFS_IRQ_MASK, 32'h6f);
      chk("irq raised", 32'h1, {31'h0, irq});
      wr(OFS_FAULT_STATUS, 32'h10);
      chk("irq cleared", 32'h0, {31'h0, irq});
   endtask : t_irq

   // ----------------------------------------------------------------
   // sequence and timeout
   // ----------------------------------------------------------------
   always @(posedge clk) begin
      cycles++;
      if (cycles == 5000) begin
         n_errors++;
         end_of_test();
      end
   end

   initial begin
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      t_reset();
      t_masked();
      t_events();
      t_already();
      t_primary();
      t_irq();
      end_of_test();
   end

endmodule : fault_event_interrupt_ctrl_tb_top

// ===== sim/msg_sink.sv
`timescale 1ns/1ps

module msg_sink
   import fault_event_pkg::*;
(
   // clock and reset
   input  wire logic                 clk,
   input  wire logic                 rst,
   // message side
   input  wire logic                 msg_valid,
   output logic                      msg_ready,
   input  wire logic [DATA_W-1:0]    msg_target,
   input  wire logic [PAYLOAD_W-1:0] msg_payload,
   // model control and record
   input  wire logic [3:0]           delay,
   output logic      [7:0]           count,
   output logic      [DATA_W-1:0]    last_target,
   output logic      [PAYLOAD_W-1:0] last_payload
);
   logic [3:0] wait_cnt;

   // ----------------------------------------------------------------
   // raise ready after delay plus one cycles of offer, accept on the next edge
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (rst || !msg_valid || msg_ready) begin
         wait_cnt  <= 4'h0;
         msg_ready <= 1'b0;
      end else if (wait_cnt >= delay) begin
         msg_ready <= 1'b1;
      end else begin
         wait_cnt <= wait_cnt + 4'h1;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         count <= 8'h00;
      end else if (msg_valid && msg_ready) begin
         count        <= count + 8'h01;
         last_target  <= msg_target;
         last_payload <= msg_payload;
      end
   end

endmodule : msg_sink
